// ---- selfprog_seq.sv ----
// flash self-programming sequencer with boot partition decode
`timescale 1ns/1ps
`default_nettype none
module selfprog_seq #(
  parameter int PROG_CYCLES = selfprog_pkg::PROG_MIN_CYC,
  parameter int ARM_CYCLES = selfprog_pkg::ARM_WINDOW_CYC
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // control/status register port
  input wire logic cs_wr_in,
  input wire logic cs_rd_in,
  input wire logic [7:0] cs_wdata_in,
  output logic [7:0] cs_rdata_out,
  // core execute strobe and operands
  input wire logic spm_exec_in,
  input wire logic [15:0] z_ptr_in,
  input wire logic [15:0] r1r0_in,
  input wire logic eeprom_write_busy_in,
  // boot size strap
  input wire logic boot_size_hi_in,
  input wire logic boot_size_lo_in,
  // core fetch address check
  input wire logic [11:0] fetch_addr_in,
  // flash array request
  output selfprog_pkg::flash_req_s flash_req_out,
  output logic flash_req_valid_out,
  // partition and core control
  output logic [11:0] boot_start_out,
  output logic [11:0] app_end_out,
  output logic [6:0] boot_pages_out,
  output logic core_halt_out,
  output logic fetch_blocked_out,
  output logic concurrent_region_busy_out
);
  // ==========================================
  // refuse settings the logic cannot serve
  if (PROG_CYCLES < selfprog_pkg::PROG_MIN_CYC || PROG_CYCLES > selfprog_pkg::PROG_MAX_CYC)
  begin : g_bad_prog
    $error("program time outside the allowed window");
  end
  if (ARM_CYCLES < 1 || ARM_CYCLES > 15)
  begin : g_bad_arm
    $error("arm window out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_PROG = 3'b100
  } seq_state_e;

  seq_state_e state_r;
  seq_state_e state_nxt;
  logic [3:0] arm_cnt_r;
  logic [3:0] arm_cnt_nxt;
  logic [4:0] cmd_r;
  logic [4:0] cmd_nxt;
  logic busy_r;
  logic busy_nxt;
  logic halt_nxt;
  logic [1:0] boot_sel_r;

  // ==========================================
  // partition decode
  logic [11:0] boot_start;
  logic [6:0] boot_pages;
  assign boot_start = (boot_sel_r == 2'b11) ? selfprog_pkg::BOOT_START_128 :
                      (boot_sel_r == 2'b10) ? selfprog_pkg::BOOT_START_256 :
                      (boot_sel_r == 2'b01) ? selfprog_pkg::BOOT_START_512 :
                      selfprog_pkg::BOOT_START_1024;
  assign boot_pages = (boot_sel_r == 2'b11) ? selfprog_pkg::BOOT_PAGES_128 :
                      (boot_sel_r == 2'b10) ? selfprog_pkg::BOOT_PAGES_256 :
                      (boot_sel_r == 2'b01) ? selfprog_pkg::BOOT_PAGES_512 :
                      selfprog_pkg::BOOT_PAGES_1024;

  // ==========================================
  // z pointer decode, bits 15:13 and 0 unused
  selfprog_pkg::flash_addr_s z_addr;
  assign z_addr.page_index = z_ptr_in[selfprog_pkg::Z_PAGE_MSB:selfprog_pkg::Z_PAGE_LSB];
  assign z_addr.word_in_page = z_ptr_in[selfprog_pkg::Z_WORD_MSB:selfprog_pkg::Z_WORD_LSB];

  // address checks on 12-bit word space
  logic fetch_in_concurrent;
  logic target_in_nocon;
  assign fetch_in_concurrent = fetch_addr_in < selfprog_pkg::NO_CONCURRENT_READ_REGION_START;
  assign target_in_nocon = {z_addr.page_index, 5'h00} >= selfprog_pkg::NO_CONCURRENT_READ_REGION_START;

  // ==========================================
  // command decode at execute
  logic exec_ok;
  logic do_erase;
  logic do_write;
  logic do_lock;
  logic do_fill;
  logic do_reen;
  logic timed_start;
  logic prog_done;
  logic prog_running;
  logic armed_expire;
  assign exec_ok = (state_r == ST_ARMED) && spm_exec_in;
  assign armed_expire = arm_cnt_r == 4'h1;
  assign do_erase = exec_ok && cmd_r[selfprog_pkg::CS_PAGE_ERASE];
  assign do_write = exec_ok && cmd_r[selfprog_pkg::CS_PAGE_WRITE];
  assign do_lock = exec_ok && cmd_r[selfprog_pkg::CS_LOCK_SET];
  assign do_reen = exec_ok && cmd_r[selfprog_pkg::CS_REENABLE];
  assign do_fill = exec_ok && (cmd_r[4:1] == 4'h0);
  assign timed_start = do_erase | do_write | do_lock;

  // writes accepted only when idle and eeprom not writing
  logic wr_take;
  assign wr_take = cs_wr_in && (state_r == ST_IDLE) && !eeprom_write_busy_in &&
                   cs_wdata_in[selfprog_pkg::CS_GO];

  // ==========================================
  // sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    arm_cnt_nxt = arm_cnt_r;
    cmd_nxt = cmd_r;
    busy_nxt = busy_r;
    halt_nxt = core_halt_out;
    unique case (state_r)
      ST_IDLE:
      begin
        if (wr_take)
        begin
          state_nxt = ST_ARMED;
          cmd_nxt = cs_wdata_in[4:0];
          arm_cnt_nxt = 4'(ARM_CYCLES);
        end
      end
      ST_ARMED:
      begin
        if (timed_start)
        begin
          state_nxt = ST_PROG;
          if (do_erase || do_write)
            busy_nxt = 1'b1;
          halt_nxt = do_write && target_in_nocon;
        end
        else if (exec_ok || armed_expire)
        begin
          state_nxt = ST_IDLE;
          cmd_nxt = 5'h00;
          if (do_reen)
            busy_nxt = 1'b0;
        end
        else
          arm_cnt_nxt = arm_cnt_r - 4'h1;
      end
      ST_PROG:
      begin
        if (prog_done)
        begin
          state_nxt = ST_IDLE;
          cmd_nxt = 5'h00;
          halt_nxt = 1'b0;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ==========================================
  // timed write duration
  selfprog_timer #(
    .COUNT(PROG_CYCLES)
  ) u_timer (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .start_in(timed_start),
    .done_out(prog_done),
    .running_out(prog_running)
  );

  // ==========================================
  // read-back image and flash request
  logic [7:0] cs_image;
  selfprog_pkg::flash_req_s req_nxt;
  assign cs_image = {1'b0, busy_r, 1'b0, cmd_r};
  assign req_nxt.erase = do_erase;
  assign req_nxt.write = do_write;
  assign req_nxt.lock = do_lock;
  assign req_nxt.fill = do_fill;
  assign req_nxt.addr = z_addr;
  assign req_nxt.data = r1r0_in;

  // next values of the registered outputs
  logic [7:0] rdata_nxt;
  logic req_valid_nxt;
  logic [11:0] app_end_nxt;
  logic blocked_nxt;
  assign rdata_nxt = cs_rd_in ? cs_image : 8'h00; // data only after a read strobe
  assign req_valid_nxt = exec_ok && (timed_start || do_fill);
  assign app_end_nxt = boot_start - 12'h001;
  assign blocked_nxt = busy_nxt && prog_running && fetch_in_concurrent;

  // state registers
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_r <= ST_IDLE;
      arm_cnt_r <= 4'h0;
      cmd_r <= 5'h00;
      busy_r <= 1'b0;
      core_halt_out <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      arm_cnt_r <= arm_cnt_nxt;
      cmd_r <= cmd_nxt;
      busy_r <= busy_nxt;
      core_halt_out <= halt_nxt;
    end
  end

  // boot size strap, sampled every cycle after reset
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      boot_sel_r <= 2'b00;
    else
      boot_sel_r <= {boot_size_hi_in, boot_size_lo_in};
  end

  // control read-back and flash request
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cs_rdata_out <= selfprog_pkg::CS_RESET;
      flash_req_out <= '0;
      flash_req_valid_out <= 1'b0;
    end
    else
    begin
      cs_rdata_out <= rdata_nxt;
      flash_req_out <= req_nxt;
      flash_req_valid_out <= req_valid_nxt;
    end
  end

  // partition outputs
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      boot_start_out <= selfprog_pkg::BOOT_START_1024;
      app_end_out <= selfprog_pkg::BOOT_START_1024 - 12'h001;
      boot_pages_out <= selfprog_pkg::BOOT_PAGES_1024;
    end
    else
    begin
      boot_start_out <= boot_start;
      app_end_out <= app_end_nxt;
      boot_pages_out <= boot_pages;
    end
  end

  // region guard outputs
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      fetch_blocked_out <= 1'b0;
      concurrent_region_busy_out <= 1'b0;
    end
    else
    begin
      fetch_blocked_out <= blocked_nxt;
      concurrent_region_busy_out <= busy_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- selfprog_pkg.sv ----
// shared constants and carriers for the flash self-programming sequencer
package selfprog_pkg;

  // ==========================================
  // address geometry
  localparam int PC_W = 12;
  localparam int WORD_W = 5;
  localparam int PAGE_W = 7;
  localparam int Z_W = 16;
  localparam int Z_WORD_LSB = 1;
  localparam int Z_WORD_MSB = 5;
  localparam int Z_PAGE_LSB = 6;
  localparam int Z_PAGE_MSB = 12;
  localparam logic [11:0] FLASH_LAST_WORD = 12'hfff;
  localparam logic [11:0] NO_CONCURRENT_READ_REGION_START = 12'hc00;
  localparam logic [11:0] BOOT_START_128 = 12'hf80;
  localparam logic [11:0] BOOT_START_256 = 12'hf00;
  localparam logic [11:0] BOOT_START_512 = 12'he00;
  localparam logic [11:0] BOOT_START_1024 = 12'hc00;
  localparam logic [6:0] BOOT_PAGES_128 = 7'h04;
  localparam logic [6:0] BOOT_PAGES_256 = 7'h08;
  localparam logic [6:0] BOOT_PAGES_512 = 7'h10;
  localparam logic [6:0] BOOT_PAGES_1024 = 7'h20;

  // ==========================================
  // control/status bit positions
  localparam int CS_GO = 0;
  localparam int CS_PAGE_ERASE = 1;
  localparam int CS_PAGE_WRITE = 2;
  localparam int CS_LOCK_SET = 3;
  localparam int CS_REENABLE = 4;
  localparam int CS_BUSY = 6;
  localparam logic [7:0] CS_RESET = 8'h00;

  // ==========================================
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam real PROG_MIN_MS = 3.7;
  localparam real PROG_MAX_MS = 4.5;
  localparam int PROG_MIN_CYC = int'($ceil(PROG_MIN_MS * CLK_HZ / 1000.0));
  localparam int PROG_MAX_CYC = int'($floor(PROG_MAX_MS * CLK_HZ / 1000.0));
  localparam int ARM_WINDOW_CYC = 4;

  // page and word address decoded from the z pointer at execute time
  typedef struct packed {
    logic [6:0] page_index;
    logic [4:0] word_in_page;
  } flash_addr_s;

  // request presented to the flash array
  typedef struct packed {
    logic erase;
    logic write;
    logic lock;
    logic fill;
    flash_addr_s addr;
    logic [15:0] data;
  } flash_req_s;

endpackage

// ---- selfprog_timer.sv ----
// cycle timer for one timed flash write
`timescale 1ns/1ps
`default_nettype none
module selfprog_timer #(
  parameter int COUNT = 148000
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // control
  input wire logic start_in,
  output logic done_out,
  output logic running_out
);
  localparam int CW = $clog2(COUNT + 1);

  // refuse a count the counter cannot serve
  if (COUNT < 1)
  begin : g_bad_count
    $error("timer count must be at least one");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic at_end;

  // ==========================================
  // countdown
  assign at_end = running_out && (cnt_r == CW'(1));
  assign cnt_nxt = start_in ? CW'(COUNT) : (running_out ? cnt_r - CW'(1) : cnt_r);

  // counter and flags
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cnt_r <= '0;
      running_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      running_out <= start_in | (running_out & ~at_end);
      done_out <= at_end;
    end
  end
endmodule
`default_nettype wire

// ---- selfprog_seq_sva.sv ----
// assertion checker for the self-programming sequencer
`timescale 1ns/1ps
`default_nettype none
module selfprog_seq_sva #(
  parameter int PROG_CYCLES = 148000,
  parameter int ARM_CYCLES = 4
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // watched inputs
  input wire logic spm_exec_in,
  input wire logic [15:0] z_ptr_in,
  input wire logic [15:0] r1r0_in,
  input wire logic boot_size_hi_in,
  input wire logic boot_size_lo_in,
  input wire logic [11:0] fetch_addr_in,
  // watched outputs
  input wire selfprog_pkg::flash_req_s flash_req_out,
  input wire logic flash_req_valid_out,
  input wire logic [11:0] boot_start_out,
  input wire logic [11:0] app_end_out,
  input wire logic [6:0] boot_pages_out,
  input wire logic core_halt_out,
  input wire logic fetch_blocked_out,
  input wire logic concurrent_region_busy_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  logic [1:0] live_r;
  logic [31:0] halt_cnt_r;
  wire logic [1:0] strap = {boot_size_hi_in, boot_size_lo_in};
  wire logic [11:0] exp_start = strap == 2'h3 ? 12'hf80 : strap == 2'h2 ? 12'hf00 :
    strap == 2'h1 ? 12'he00 : 12'hc00;
  // cycles since reset, held at three, and length of a halt
  always_ff @(posedge core_clk_in or negedge resetn_in)
    if (!resetn_in)
    begin
      live_r <= 2'h0;
      halt_cnt_r <= 32'h0;
    end
    else
    begin
      live_r <= (live_r == 2'h3) ? live_r : live_r + 2'h1;
      halt_cnt_r <= core_halt_out ? halt_cnt_r + 32'h1 : 32'h0;
    end
  sequence s_strap_steady;
    (live_r == 2'h3 && $stable(strap)) [*3];
  endsequence
  sequence s_top_write;
    flash_req_valid_out && flash_req_out.write && flash_req_out.addr.page_index >= 7'h60;
  endsequence
  // ==========================================
  // partition, request, halt and fetch block checks
  a_boot_start: assert property (s_strap_steady |-> boot_start_out == exp_start)
    else $error("boot start does not follow strap");
  a_app_end: assert property (app_end_out == boot_start_out - 12'h1)
    else $error("application end not below boot start");
  a_boot_pages: assert property (boot_pages_out == 7'((13'h1000 - {1'b0, boot_start_out}) >> 5))
    else $error("boot page count wrong");
  a_req_from_exec: assert property (flash_req_valid_out |-> $past(spm_exec_in))
    else $error("flash request without execute");
  a_req_address: assert property (flash_req_valid_out |->
    flash_req_out.addr == {$past(z_ptr_in[12:6]), $past(z_ptr_in[5:1])})
    else $error("request address not from z pointer");
  a_fill_data: assert property (flash_req_valid_out && flash_req_out.fill |->
    flash_req_out.data == $past(r1r0_in))
    else $error("fill data not from register pair");
  a_busy_on_prog: assert property (flash_req_valid_out && (flash_req_out.erase ||
    flash_req_out.write) |-> concurrent_region_busy_out)
    else $error("busy flag not set by erase or write");
  a_halt_top_write: assert property (s_top_write |-> ##[0:2] core_halt_out)
    else $error("core not halted for top region write");
  a_halt_bound: assert property (halt_cnt_r <= 32'(PROG_CYCLES + 4))
    else $error("halt lasts too long");
  a_fetch_block: assert property (fetch_blocked_out |-> $past(fetch_addr_in) < 12'hc00)
    else $error("fetch blocked outside concurrent region");
  a_halt_min: assert property ($fell(core_halt_out) |-> halt_cnt_r >= 32'(PROG_CYCLES))
    else $error("halt ended before the program time");
endmodule
bind selfprog_seq selfprog_seq_sva #(.PROG_CYCLES(PROG_CYCLES), .ARM_CYCLES(ARM_CYCLES)) sva_u (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in), .spm_exec_in(spm_exec_in),
  .z_ptr_in(z_ptr_in), .r1r0_in(r1r0_in), .boot_size_hi_in(boot_size_hi_in),
  .boot_size_lo_in(boot_size_lo_in), .fetch_addr_in(fetch_addr_in),
  .flash_req_out(flash_req_out), .flash_req_valid_out(flash_req_valid_out),
  .boot_start_out(boot_start_out), .app_end_out(app_end_out), .boot_pages_out(boot_pages_out),
  .core_halt_out(core_halt_out), .fetch_blocked_out(fetch_blocked_out),
  .concurrent_region_busy_out(concurrent_region_busy_out));
`default_nettype wire

// ---- selfprog_core_model.sv ----
// behavioural core running the boot loader command sequence
`timescale 1ns/1ps
`default_nettype none
module selfprog_core_model (
  // clock and status
  input wire logic core_clk_in,
  input wire logic [7:0] cs_rdata_in,
  input wire logic eeprom_write_busy_in,
  // control port and execute
  output logic cs_wr_out,
  output logic cs_rd_out,
  output logic [7:0] cs_wdata_out,
  output logic spm_exec_out,
  output logic [15:0] z_ptr_out,
  output logic [15:0] r1r0_out
);
  // idle bus at time zero
  initial
  begin
    {cs_wr_out, cs_rd_out, spm_exec_out} = 3'h0;
    {cs_wdata_out, z_ptr_out, r1r0_out} = 40'h0;
  end
  // one control write
  task automatic wr(input logic [7:0] v);
    @(posedge core_clk_in);
    cs_wr_out <= 1'b1;
    cs_wdata_out <= v;
    @(posedge core_clk_in);
    cs_wr_out <= 1'b0;
  endtask
  // one control read, data in the following cycle
  task automatic rd(output logic [7:0] v);
    @(posedge core_clk_in);
    cs_rd_out <= 1'b1;
    @(posedge core_clk_in);
    cs_rd_out <= 1'b0;
    #1 v = cs_rdata_in;
  endtask
  // execute strobe with pointer and fill word
  task automatic ex(input logic [15:0] z, input logic [15:0] d);
    @(posedge core_clk_in);
    spm_exec_out <= 1'b1;
    z_ptr_out <= z;
    r1r0_out <= d;
    @(posedge core_clk_in);
    spm_exec_out <= 1'b0;
  endtask
  // full command: wait idle, wait eeprom, write, execute at once
  task automatic do_spm(input logic [7:0] cmd, input logic [15:0] z, input logic [15:0] d);
    logic [7:0] v;
    rd(v);
    while (v[selfprog_pkg::CS_GO] !== 1'b0)
      rd(v);
    while (eeprom_write_busy_in !== 1'b0)
      @(posedge core_clk_in);
    wr(cmd);
    ex(z, d);
  endtask
endmodule
`default_nettype wire

// ---- test_selfprog_seq.sv ----
// self-checking testbench for the self-programming sequencer
`timescale 1ns/1ps
`default_nettype none
module test_selfprog_seq;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic ee_busy = 1'b0;
  logic bs_hi = 1'b0;
  logic bs_lo = 1'b0;
  logic [11:0] fetch = 12'hc00;
  wire logic cs_wr, cs_rd, spm_exec;
  wire logic [7:0] cs_wdata;
  wire logic [15:0] z_ptr, r1r0;
  logic [7:0] rdata, v;
  selfprog_pkg::flash_req_s req_out, req;
  logic req_valid, halt, blocked, busy, got;
  logic [11:0] start, app_end;
  logic [6:0] pages;
  logic [15:0] z, d;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  int i, n;
  // ==========================================
  // clock, design and core model
  always #12.5 core_clk_in = ~core_clk_in;
  selfprog_seq dut_u (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .cs_wr_in(cs_wr),
    .cs_rd_in(cs_rd), .cs_wdata_in(cs_wdata), .cs_rdata_out(rdata), .spm_exec_in(spm_exec),
    .z_ptr_in(z_ptr), .r1r0_in(r1r0), .eeprom_write_busy_in(ee_busy), .boot_size_hi_in(bs_hi),
    .boot_size_lo_in(bs_lo), .fetch_addr_in(fetch), .flash_req_out(req_out),
    .flash_req_valid_out(req_valid), .boot_start_out(start), .app_end_out(app_end),
    .boot_pages_out(pages), .core_halt_out(halt), .fetch_blocked_out(blocked),
    .concurrent_region_busy_out(busy));
  selfprog_core_model core_u (.core_clk_in(core_clk_in), .cs_rdata_in(rdata),
    .eeprom_write_busy_in(ee_busy), .cs_wr_out(cs_wr), .cs_rd_out(cs_rd), .cs_wdata_out(cs_wdata),
    .spm_exec_out(spm_exec), .z_ptr_out(z_ptr), .r1r0_out(r1r0));
  // ==========================================
  // helpers
  function automatic logic [11:0] exp_start(input logic [1:0] s);
    return s == 2'h3 ? 12'hf80 : s == 2'h2 ? 12'hf00 : s == 2'h1 ? 12'he00 : 12'hc00;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic get_req(output logic ok);
    ok = 1'b0;
    for (int k = 0; k < 4 && !ok; k++)
    begin
      #1;
      if (req_valid === 1'b1)
      begin
        ok = 1'b1;
        req = req_out;
      end
      else
        @(posedge core_clk_in);
    end
  endtask
  task automatic pulse_reset;
    resetn_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    resetn_in <= 1'b1;
  endtask
  task automatic end_sim;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // cut a hang short
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 200000)
    begin
      miscompares++;
      end_sim();
    end
  end
  // ==========================================
  // main sequence
  initial
  begin
    void'($urandom(97));
    repeat (16) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      {bs_hi, bs_lo} <= 2'(i);
      repeat (4) @(posedge core_clk_in);
      #1;
      chk(start, exp_start(2'(i)));
      chk(app_end, exp_start(2'(i)) - 12'h1);
      chk(pages, 7'((13'h1000 - {1'b0, exp_start(2'(i))}) >> 5));
    end
    for (i = 0; i < 8; i++)
    begin
      z = (i == 0) ? 16'he03e : 16'($urandom) & 16'hfffe;
      d = 16'($urandom);
      core_u.do_spm(8'h01, z, d);
      get_req(got);
      chk({got, req.fill}, 2'h3);
      chk(req.addr, {z[12:6], z[5:1]});
      chk(req.data, d);
    end
    core_u.wr(8'h03);
    repeat (6) @(posedge core_clk_in);
    core_u.rd(v);
    chk(v[4:0], 5'h0);
    core_u.ex(16'h0000, 16'h0000);
    get_req(got);
    chk(got, 1'b0);
    ee_busy <= 1'b1;
    core_u.wr(8'h01);
    core_u.ex(z, d);
    get_req(got);
    chk(got, 1'b0);
    ee_busy <= 1'b0;
    fetch <= 12'h100;
    // erase and lock, each cut short by a reset once under way
    core_u.do_spm(8'h03, 16'h0040, 16'h0000);
    get_req(got);
    chk({got, req.erase, req.addr.page_index}, {2'h3, 7'h01});
    @(posedge core_clk_in);
    #1;
    chk({busy, blocked}, 2'h3);
    core_u.rd(v);
    chk({v[selfprog_pkg::CS_BUSY], v[selfprog_pkg::CS_GO]}, 2'h3);
    pulse_reset();
    @(posedge core_clk_in);
    #1;
    chk({busy, blocked, req_valid}, 3'h0);
    core_u.do_spm(8'h09, 16'h0000, 16'h00ff);
    get_req(got);
    chk({got, req.lock, busy}, 3'h6);
    core_u.rd(v);
    chk(v[selfprog_pkg::CS_GO], 1'b1);
    pulse_reset();
    core_u.do_spm(8'h05, 16'h1fc0, 16'h0000);
    @(posedge core_clk_in);
    #1;
    chk({halt, busy, blocked}, 3'h7);
    n = 0;
    while (halt === 1'b1 && n < 190000)
    begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    chk(n >= selfprog_pkg::PROG_MIN_CYC - 2 && n <= selfprog_pkg::PROG_MAX_CYC, 1'b1);
    core_u.rd(v);
    chk({v[selfprog_pkg::CS_BUSY], v[selfprog_pkg::CS_GO]}, 2'h2);
    core_u.do_spm(8'h11, 16'h0000, 16'h0000);
    core_u.rd(v);
    chk({v[selfprog_pkg::CS_BUSY], busy}, 2'h0);
    end_sim();
  end
endmodule
`default_nettype wire
